//--- src/vdf_defines.svh
/*
 * register offsets, field positions, reset values and counts of the
 * virtual display fetch block.
 * assumes it is included by bare name, by the package and the modules.
 */
`ifndef VDF_DEFINES_SVH
`define VDF_DEFINES_SVH

// register offsets on the 8-bit register port
`define VDF_REG_MODE        8'h02
`define VDF_REG_HWIDTH      8'h04
`define VDF_REG_VLINES_LO   8'h06
`define VDF_REG_VLINES_HI   8'h07
`define VDF_REG_STATUS      8'h08
`define VDF_REG_START_LO    8'h0c
`define VDF_REG_START_HI    8'h0d
`define VDF_REG_STRIDE_OFS  8'h12

// field widths
`define VDF_START_W         15
`define VDF_OFS_W           8
`define VDF_VL_W            10
`define VDF_ADDR_W          16

// mode register fields
`define VDF_MODE_BPP_LSB    0
`define VDF_MODE_ROT_BIT    2
`define VDF_MODE_EN_BIT     7

// status register fields
`define VDF_STAT_FRAME_BIT  0
`define VDF_STAT_LINE_BIT   1
`define VDF_STAT_ROT_BIT    2
`define VDF_STAT_STEP_LSB   3

// reset values
`define VDF_RST_START       15'h0000
`define VDF_RST_OFS         8'h00
`define VDF_RST_HWIDTH      8'h14
`define VDF_RST_VLINES      10'h0f0

// display memory size in bytes
`define VDF_MEM_BYTES       40960

// blanking lengths in pixel-rate ticks, and the tick divider
`define VDF_HBLANK_TICKS    8'h08
`define VDF_VBLANK_TICKS    8'h20
`define VDF_TICK_DIV        4

`endif

//--- src/vdf_pkg.sv
/*
 * types of the virtual display fetch block: modes, states, carriers and
 * the packed state record of the main module.
 * assumes vdf_defines.svh is on the include path.
 */
`include "vdf_defines.svh"

package vdf_pkg;

	// colour depth code held in the mode register
	typedef enum logic [1:0] {
		BPP1 = 2'h0,
		BPP2 = 2'h1,
		BPP4 = 2'h2,
		BPP8 = 2'h3
	} vdf_bpp_type;

	// fetch sequencer states, one-hot
	typedef enum logic [3:0] {
		ST_IDLE   = 4'h1,
		ST_LINE   = 4'h2,
		ST_HBLANK = 4'h4,
		ST_VBLANK = 4'h8
	} vdf_state_type;

	// register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} vdf_bus_req_type;

	// fetch request towards display memory and panel path
	typedef struct packed {
		logic [`VDF_ADDR_W-1:0] addr;
		logic                   valid;
		logic                   line_start;
		logic                   frame_start;
	} vdf_fetch_type;

	// settings, live copy and per-frame copy
	typedef struct packed {
		logic [`VDF_START_W-1:0] start;
		logic [`VDF_OFS_W-1:0]   ofs;
		logic [7:0]              hwidth;
		logic [`VDF_VL_W-1:0]    vlines;
		vdf_bpp_type             bpp;
		logic                    rot;
		logic                    en;
	} vdf_cfg_type;

	// whole state of the main module
	typedef struct packed {
		vdf_cfg_type            cfg;
		vdf_cfg_type            frm;
		vdf_state_type          fsm;
		logic [`VDF_ADDR_W-1:0] line_base;
		logic [7:0]             word_cnt;
		logic [`VDF_VL_W-1:0]   line_cnt;
		logic [7:0]             blank_cnt;
		logic [7:0]             tick_cnt;
		logic                   tick;
		logic [7:0]             rdata;
		logic [4:0]             pan_step;
		vdf_fetch_type          fetch;
	} vdf_state_rec_type;

endpackage

//--- src/vdf_addr_wrap.sv
/*
 * adds a byte increment to a display memory byte address and folds the
 * sum back into the display memory.
 * assumes base is below MEM_BYTES and the sum stays below twice it.
 */
`timescale 1ns/100ps
`include "vdf_defines.svh"

module vdf_addr_wrap #(
	parameter int MEM_BYTES = `VDF_MEM_BYTES
) (
	// operands
	input  wire logic [`VDF_ADDR_W-1:0] BASE,
	input  wire logic [`VDF_ADDR_W-1:0] INCR,
	// folded sum
	output logic      [`VDF_ADDR_W-1:0] SUM
);

	localparam logic [`VDF_ADDR_W:0] MEM_SIZE = (`VDF_ADDR_W+1)'(MEM_BYTES);

	logic [`VDF_ADDR_W:0] raw;

	// one subtraction is enough while both operands stay below the size
	always_comb begin
		raw = {1'b0, BASE} + {1'b0, INCR};
		if (raw >= MEM_SIZE) begin
			raw = raw - MEM_SIZE;
		end
		SUM = raw[`VDF_ADDR_W-1:0];
	end

endmodule // vdf_addr_wrap

//--- src/vdf_fetch.sv
/*
 * virtual display fetch address generator: registers for start address,
 * line stride offset, width, height and mode, and a sequencer that emits
 * display memory byte addresses line by line, frame by frame.
 * assumes one 125 MHz clock, a synchronous active-low reset, a register
 * master on the same clock and a memory/panel path that takes a fetch
 * when it raises FETCH_READY.
 * it also assumes software sets width, offset and line count before it
 * sets the enable bit, and never raises both strobes in one cycle.
 * limitations: one screen region only and no palette; a zero width or
 * line count is served as one word or one line, so a frame always ends;
 * a disable written mid-frame lets the running frame finish first.
 * the fetch request stands until taken, so a slow panel path stretches
 * a line instead of losing words; blanking is timed in divider ticks.
 * settings are copied at frame start, so a rewrite costs at most one
 * frame of latency but can never tear the picture.
 */
// The implementer's own choice: strobed register access.
// Behaviour
// - line offset is 8 bits, adding 0..255 words to each line stride
// - zero offset makes the stride equal to the visible width
// - visible width comes from its own register; offset counts extras only
// - display memory is 40960 bytes; addresses wrap within it
// - landscape start address is a word offset, first word at top left
// - each frame begins at the top left, lines fetched downward
// - landscape pan step is one word: 16, 8, 4 or 2 pixels
// - rotated mode start address counts bytes, pan step halved
// - start address 15 bits, low byte and high seven bits, bit 7 reserved
`timescale 1ns/100ps
`include "vdf_defines.svh"

module vdf_fetch #(
	parameter int MEM_BYTES = `VDF_MEM_BYTES,
	parameter int TICK_DIV  = `VDF_TICK_DIV
) (
	// clock and reset
	input  wire logic                     CLK,
	input  wire logic                     RESETN,
	// register port
	input  wire vdf_pkg::vdf_bus_req_type REG_REQ,
	output logic      [7:0]               REG_RDATA,
	// fetch path
	output vdf_pkg::vdf_fetch_type        FETCH,
	input  wire logic                     FETCH_READY,
	// pixels moved by one step of the start address
	output logic      [4:0]               PAN_STEP
);

	// refuse sizes the single-subtraction wrap or the tick counter cannot serve;
	// these checks act at elaboration, before any clock runs
	if (MEM_BYTES < 32768 || MEM_BYTES > 65536) begin : g_bad_mem_size
		$error("vdf_fetch: MEM_BYTES out of range");
	end
	// an odd size would let a word straddle the fold point
	if (MEM_BYTES % 2 != 0) begin : g_bad_mem_odd
		$error("vdf_fetch: MEM_BYTES must be even");
	end
	if (TICK_DIV < 1 || TICK_DIV > 256) begin : g_bad_tick
		$error("vdf_fetch: TICK_DIV out of range");
	end
	// the start address, doubled, must fit the byte address bus
	if (`VDF_START_W + 1 > `VDF_ADDR_W) begin : g_bad_addr_w
		$error("vdf_fetch: address bus too narrow for the start address");
	end

	localparam logic [7:0] TICK_LAST = 8'(TICK_DIV - 1);

	vdf_pkg::vdf_state_rec_type st;
	vdf_pkg::vdf_state_rec_type next_st;

	// adder operands and results, and the settings in byte units
	logic [`VDF_ADDR_W-1:0] word_sum;
	logic [`VDF_ADDR_W-1:0] line_in_base;
	logic [`VDF_ADDR_W-1:0] line_in_incr;
	logic [`VDF_ADDR_W-1:0] line_sum;
	logic [`VDF_ADDR_W-1:0] start_bytes;
	logic [`VDF_ADDR_W-1:0] stride_bytes;
	logic [8:0]             line_words;
	logic                   take;

	// pixels held in one 16-bit word at a colour depth
	// the panel path unpacks the word; this only counts its pixels
	function automatic logic [4:0] pix_per_word(input vdf_pkg::vdf_bpp_type bpp);
		case (bpp)
			vdf_pkg::BPP1: pix_per_word = 5'h10;
			vdf_pkg::BPP2: pix_per_word = 5'h08;
			vdf_pkg::BPP4: pix_per_word = 5'h04;
			default:       pix_per_word = 5'h02;
		endcase
	endfunction

	// pixels moved by one start address step; a byte is half a word
	// latched at frame start so the status byte matches the picture shown
	function automatic logic [4:0] pan_pixels(input vdf_pkg::vdf_cfg_type c);
		if (c.rot) begin
			pan_pixels = pix_per_word(c.bpp) >> 1;
		end else begin
			pan_pixels = pix_per_word(c.bpp);
		end
	endfunction

	// byte address of the first fetch of a frame
	// the live start is read here, since only idle uses it to place a frame
	always_comb begin
		if (st.cfg.rot) begin
			start_bytes = {1'b0, st.cfg.start};
		end else begin
			start_bytes = {st.cfg.start, 1'b0};
		end
	end

	// memory stride of one line: visible words plus extra words, in bytes;
	// the word sum needs nine bits, since both terms may reach 255
	always_comb begin
		line_words = {1'b0, st.frm.hwidth} + {1'b0, st.frm.ofs};
		stride_bytes = {6'h00, line_words, 1'b0};
	end

	// the line adder also places the frame start, so one adder serves both
	always_comb begin
		if (st.fsm == vdf_pkg::ST_IDLE) begin
			line_in_base = '0;
			line_in_incr = start_bytes;
		end else begin
			line_in_base = st.line_base;
			line_in_incr = stride_bytes;
		end
	end

	// next word along the current line
	// a line that runs past the end of memory continues at address zero, or at one when its byte address is odd
	vdf_addr_wrap #(
		.MEM_BYTES (MEM_BYTES)
	) u_word_wrap (
		.BASE (st.fetch.addr),
		.INCR (16'h0002),
		.SUM  (word_sum)
	);

	// next line base, or frame base while idle
	// a doubled start address beyond the memory end folds the same way
	vdf_addr_wrap #(
		.MEM_BYTES (MEM_BYTES)
	) u_line_wrap (
		.BASE (line_in_base),
		.INCR (line_in_incr),
		.SUM  (line_sum)
	);

	// a fetch is taken when valid and ready meet at a rising edge
	assign take = st.fetch.valid & FETCH_READY;

	// next state: registers, read data, divider and sequencer
	always_comb begin
		next_st = st;
		next_st.fetch.line_start  = 1'b0;
		next_st.fetch.frame_start = 1'b0;
		next_st.rdata = 8'h00;

		// pixel-rate enable used to time the blanking gaps
		// with a divider of one the tick stands high on every cycle
		if (st.tick_cnt == TICK_LAST) begin
			next_st.tick_cnt = 8'h00;
			next_st.tick = 1'b1;
		end else begin
			next_st.tick_cnt = st.tick_cnt + 8'h01;
			next_st.tick = 1'b0;
		end

		// register writes land in the live copy only
		if (REG_REQ.wr) begin
			case (REG_REQ.addr)
				`VDF_REG_START_LO: begin
					next_st.cfg.start[7:0] = REG_REQ.wdata;
				end
				// bit 7 of the high byte is reserved and never stored
				`VDF_REG_START_HI: begin
					next_st.cfg.start[14:8] = REG_REQ.wdata[6:0];
				end
				// the offset counts extra words only, never the visible ones
				`VDF_REG_STRIDE_OFS: begin
					next_st.cfg.ofs = REG_REQ.wdata;
				end
				`VDF_REG_HWIDTH: begin
					next_st.cfg.hwidth = REG_REQ.wdata;
				end
				// line count: low byte, then two high bits
				`VDF_REG_VLINES_LO: begin
					next_st.cfg.vlines[7:0] = REG_REQ.wdata;
				end
				`VDF_REG_VLINES_HI: begin
					next_st.cfg.vlines[9:8] = REG_REQ.wdata[1:0];
				end
				// depth, orientation and enable share one byte
				`VDF_REG_MODE: begin
					next_st.cfg.bpp = vdf_pkg::vdf_bpp_type'(
						REG_REQ.wdata[`VDF_MODE_BPP_LSB +: 2]);
					next_st.cfg.rot = REG_REQ.wdata[`VDF_MODE_ROT_BIT];
					next_st.cfg.en  = REG_REQ.wdata[`VDF_MODE_EN_BIT];
				end
				default: begin
				end
			endcase
		end

		// register reads answer in the next cycle; unmapped reads give zero
		if (REG_REQ.rd) begin
			case (REG_REQ.addr)
				`VDF_REG_START_LO: begin
					next_st.rdata = st.cfg.start[7:0];
				end
				`VDF_REG_START_HI: begin
					next_st.rdata = {1'b0, st.cfg.start[14:8]};
				end
				`VDF_REG_STRIDE_OFS: begin
					next_st.rdata = st.cfg.ofs;
				end
				`VDF_REG_HWIDTH: begin
					next_st.rdata = st.cfg.hwidth;
				end
				`VDF_REG_VLINES_LO: begin
					next_st.rdata = st.cfg.vlines[7:0];
				end
				`VDF_REG_VLINES_HI: begin
					next_st.rdata = {6'h00, st.cfg.vlines[9:8]};
				end
				// mode reads back as written, unused bits as zero
				`VDF_REG_MODE: begin
					next_st.rdata = 8'h00;
					next_st.rdata[`VDF_MODE_BPP_LSB +: 2] = st.cfg.bpp;
					next_st.rdata[`VDF_MODE_ROT_BIT] = st.cfg.rot;
					next_st.rdata[`VDF_MODE_EN_BIT] = st.cfg.en;
				end
				// the status byte reports the running frame, not the live settings
				`VDF_REG_STATUS: begin
					next_st.rdata = 8'h00;
					next_st.rdata[`VDF_STAT_FRAME_BIT] = (st.fsm != vdf_pkg::ST_IDLE);
					next_st.rdata[`VDF_STAT_LINE_BIT] = (st.fsm == vdf_pkg::ST_LINE);
					next_st.rdata[`VDF_STAT_ROT_BIT] = st.frm.rot;
					next_st.rdata[`VDF_STAT_STEP_LSB +: 5] = st.pan_step;
				end
				default: begin
					next_st.rdata = 8'h00;
				end
			endcase
		end

		// fetch sequencer
		case (st.fsm)
			// a frame starts only from idle, so settings are taken only here
			vdf_pkg::ST_IDLE: begin
				if (st.cfg.en) begin
					// freeze the settings so a write mid-frame cannot tear it
					next_st.frm = st.cfg;
					next_st.pan_step = pan_pixels(st.cfg);
					next_st.line_base = line_sum;
					next_st.fetch.addr = line_sum;
					next_st.fetch.valid = 1'b1;
					next_st.fetch.line_start = 1'b1;
					next_st.fetch.frame_start = 1'b1;
					next_st.word_cnt = 8'h00;
					next_st.line_cnt = '0;
					next_st.fsm = vdf_pkg::ST_LINE;
				end
			end

			// each take moves to the next word; the last one ends the line
			vdf_pkg::ST_LINE: begin
				if (take) begin
					// a zero width still fetches one word, to keep the line finite
					if ({1'b0, st.word_cnt} + 9'h001 >= {1'b0, st.frm.hwidth}) begin
						next_st.fetch.valid = 1'b0;
						next_st.line_base = line_sum;
						next_st.line_cnt = st.line_cnt + 10'h001;
						next_st.blank_cnt = 8'h00;
						if ({1'b0, st.line_cnt} + 11'h001 >= {1'b0, st.frm.vlines}) begin
							next_st.fsm = vdf_pkg::ST_VBLANK;
						end else begin
							next_st.fsm = vdf_pkg::ST_HBLANK;
						end
					end else begin
						// still inside the line: step one word, folding at the memory end
						next_st.fetch.addr = word_sum;
						next_st.word_cnt = st.word_cnt + 8'h01;
					end
				end
			end

			// the line base was advanced when the previous line ended
			vdf_pkg::ST_HBLANK: begin
				if (st.tick) begin
					if (st.blank_cnt + 8'h01 >= `VDF_HBLANK_TICKS) begin
						next_st.fetch.addr = st.line_base;
						next_st.fetch.valid = 1'b1;
						next_st.fetch.line_start = 1'b1;
						next_st.word_cnt = 8'h00;
						next_st.fsm = vdf_pkg::ST_LINE;
					end else begin
						next_st.blank_cnt = st.blank_cnt + 8'h01;
					end
				end
			end

			// back to idle, where the enable decides about the next frame
			vdf_pkg::ST_VBLANK: begin
				if (st.tick) begin
					if (st.blank_cnt + 8'h01 >= `VDF_VBLANK_TICKS) begin
						next_st.fsm = vdf_pkg::ST_IDLE;
					end else begin
						next_st.blank_cnt = st.blank_cnt + 8'h01;
					end
				end
			end
			default: begin
				// an illegal state drops the request and recovers in idle
				next_st.fetch.valid = 1'b0;
				next_st.fsm = vdf_pkg::ST_IDLE;
			end
		endcase
	end

	// state register; reset loads constants only
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			// settings come up at their reset values and the sequencer idles
			st <= '0;
			st.cfg.start <= `VDF_RST_START;
			st.cfg.ofs <= `VDF_RST_OFS;
			st.cfg.hwidth <= `VDF_RST_HWIDTH;
			st.cfg.vlines <= `VDF_RST_VLINES;
			st.cfg.bpp <= vdf_pkg::BPP1;
			st.frm.bpp <= vdf_pkg::BPP1;
			st.fsm <= vdf_pkg::ST_IDLE;
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from the state flops
	// every output is a flop, so the panel path never sees a glitch
	assign REG_RDATA = st.rdata;
	assign FETCH = st.fetch;
	assign PAN_STEP = st.pan_step;

endmodule // vdf_fetch

//--- bench/vdf_fetch_monitor.sv
/*
 * port assertions for the fetch block: register reads, held fetches,
 * word stepping and frame pulses.
 * assumes it is bound onto vdf_fetch, one clock, synchronous reset.
 */
`timescale 1ns/100ps

module vdf_fetch_monitor #(
	parameter int MEM_BYTES = 40960
) (
	// clock and reset
	input wire logic                     CLK,
	input wire logic                     RESETN,
	// register port
	input wire vdf_pkg::vdf_bus_req_type REG_REQ,
	input wire logic [7:0]               REG_RDATA,
	// fetch path
	input wire vdf_pkg::vdf_fetch_type   FETCH,
	input wire logic                     FETCH_READY,
	// pan step of the running frame
	input wire logic [4:0]               PAN_STEP
);
	logic [7:0]  sh_lo;
	logic [6:0]  sh_hi;
	logic [7:0]  sh_ofs;
	logic [15:0] addr_next;

	default clocking @(posedge CLK); endclocking
	default disable iff (!RESETN);

	// shadows of written registers predict what a read must return
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			sh_lo  <= 8'h00;
			sh_hi  <= 7'h00;
			sh_ofs <= 8'h00;
		end else if (REG_REQ.wr) begin
			if (REG_REQ.addr == 8'h0c)
				sh_lo <= REG_REQ.wdata;
			if (REG_REQ.addr == 8'h0d)
				sh_hi <= REG_REQ.wdata[6:0];
			if (REG_REQ.addr == 8'h12)
				sh_ofs <= REG_REQ.wdata;
		end
	end

	// next word address folded back into display memory
	assign addr_next = (32'(FETCH.addr) + 2 >= MEM_BYTES) ?
		16'(32'(FETCH.addr) + 2 - MEM_BYTES) : FETCH.addr + 16'h2;

	sequence s_rd(a);
		REG_REQ.rd && REG_REQ.addr == a;
	endsequence
	sequence s_take;
		FETCH.valid && FETCH_READY;
	endsequence

	chk_start_low: assert property (s_rd(8'h0c) |=> REG_RDATA == $past(sh_lo))
		else $error("start low read wrong");
	chk_start_high: assert property (s_rd(8'h0d) |=> REG_RDATA == {1'b0, $past(sh_hi)})
		else $error("start high read wrong");
	chk_offset_read: assert property (s_rd(8'h12) |=> REG_RDATA == $past(sh_ofs))
		else $error("line offset read wrong");
	chk_rdata_idle: assert property (!REG_REQ.rd |=> REG_RDATA == 8'h00)
		else $error("read data outside read slot");
	chk_fetch_hold: assert property (FETCH.valid && !FETCH_READY |=>
		FETCH.valid && $stable(FETCH.addr))
		else $error("fetch dropped before taken");
	chk_word_step: assert property (s_take |=> !FETCH.valid || FETCH.line_start ||
		FETCH.addr == $past(addr_next))
		else $error("fetch address did not step by one word");
	chk_frame_first: assert property (FETCH.frame_start |-> FETCH.line_start && FETCH.valid)
		else $error("frame pulse without first fetch");
	chk_pulse_short: assert property (FETCH.line_start |=> !FETCH.line_start)
		else $error("line pulse longer than one cycle");
	chk_status_pan: assert property (s_rd(8'h08) |=> REG_RDATA[7:3] == $past(PAN_STEP))
		else $error("status pan step differs");
endmodule // vdf_fetch_monitor

bind vdf_fetch vdf_fetch_monitor #(.MEM_BYTES(MEM_BYTES)) u_mon (
	.CLK(CLK),
	.RESETN(RESETN),
	.REG_REQ(REG_REQ),
	.REG_RDATA(REG_RDATA),
	.FETCH(FETCH),
	.FETCH_READY(FETCH_READY),
	.PAN_STEP(PAN_STEP)
);

//--- bench/vdf_panel_model.sv
/*
 * panel side of the fetch path: takes fetches at once, or one in four.
 * assumes the fetch block's clock and synchronous active-low reset.
 */
`timescale 1ns/100ps

module vdf_panel_model (
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   resetn,
	// fetch path
	input  wire vdf_pkg::vdf_fetch_type fetch,
	output logic                        ready,
	// stall control
	input  wire logic                   slow
);
	logic [1:0] cnt;

	// a slow panel stalls held requests, proving they stand until taken
	always_ff @(posedge clk) begin
		if (!resetn) begin
			cnt   <= 2'h0;
			ready <= 1'b0;
		end else begin
			cnt   <= fetch.valid ? cnt + 2'h1 : 2'h0;
			ready <= !slow || cnt == 2'h2;
		end
	end
endmodule // vdf_panel_model

//--- bench/tb_vdf_fetch.sv
/*
 * bench for the fetch block: register access, frame addresses in both
 * orientations and all depths, pan step, stalls, mid-frame rewrites.
 * assumes the panel model and the port monitor are compiled with it.
 */
`timescale 1ns/100ps

module tb_vdf_fetch;
	logic                     clk;
	logic                     resetn;
	vdf_pkg::vdf_bus_req_type req;
	logic [7:0]               rdata;
	vdf_pkg::vdf_fetch_type   fetch;
	logic                     ready;
	logic [4:0]               pan;
	logic                     slow;
	logic [7:0]               d;
	int                       mismatches;
	int                       total_checks;
	logic [7:0]               ra[4] = '{8'h0c, 8'h0d, 8'h12, 8'h30};
	logic [7:0]               rv[4] = '{8'hff, 8'h7f, 8'hff, 8'h00};
	logic [14:0]              sa[8] = '{15'h0005, 15'h4fff, 15'h7fff, 15'h0007,
		15'h0c80, 15'h0001, 15'h4fff, 15'h1234};
	logic [7:0]               oa[8] = '{8'h00, 8'hff, 8'h28, 8'h01,
		8'h00, 8'hff, 8'h07, 8'h03};

	vdf_fetch #(.MEM_BYTES(40960), .TICK_DIV(1)) dut (
		.CLK(clk),
		.RESETN(resetn),
		.REG_REQ(req),
		.REG_RDATA(rdata),
		.FETCH(fetch),
		.FETCH_READY(ready),
		.PAN_STEP(pan)
	);
	vdf_panel_model panel (
		.clk(clk),
		.resetn(resetn),
		.fetch(fetch),
		.ready(ready),
		.slow(slow)
	);

	// 125 MHz clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic end_sim;
		if (mismatches == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		req.wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		req.rd <= 1'b0;
		@(negedge clk);
		v = rdata;
	endtask

	// one two-line frame; start and offset are spoiled mid-frame on purpose
	task automatic run_frame(input logic [14:0] st, input logic [7:0] ofs,
		input logic [7:0] w, input logic [1:0] bpp, input logic rot);
		int base;
		int cnt;
		base = rot ? int'(st) : 2 * int'(st);
		wr(8'h0c, st[7:0]);
		wr(8'h0d, {1'b0, st[14:8]});
		wr(8'h12, ofs);
		wr(8'h04, w);
		wr(8'h06, 8'h02);
		wr(8'h07, 8'h00);
		wr(8'h02, {1'b1, 4'h0, rot, bpp});
		fork
			for (int n = 0; n < 2; n++) begin
				for (int k = 0; k < w; k++) begin
					cnt = 0;
					do begin
						@(negedge clk);
						cnt++;
					end while (!(fetch.valid && ready) && cnt < 300);
					// a fetch that never comes counts against the run
					if (!(fetch.valid && ready)) begin
						mismatches++;
					end
					chk(fetch.addr, 16'((base + n * 2 * (w + ofs) + 2 * k) % 40960));
					@(posedge clk);
				end
			end
			begin
				wait (fetch.frame_start);
				wr(8'h0c, ~st[7:0]);
				wr(8'h12, ~ofs);
				wr(8'h02, {5'h00, rot, bpp});
			end
		join
		chk(16'(pan), 16'((5'h10 >> bpp) >> rot));
		rd(8'h08, d);
		chk(16'(d), 16'({5'((5'h10 >> bpp) >> rot), rot, 2'b01}));
	endtask

	// main sequence
	initial begin
		req          = '0;
		resetn       = 1'b0;
		slow         = 1'b0;
		mismatches   = 0;
		total_checks = 0;
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		foreach (ra[i]) begin
			rd(ra[i], d);
			chk(16'(d), 16'h0000);
			wr(ra[i], 8'hff);
			rd(ra[i], d);
			chk(16'(d), 16'(rv[i]));
		end
		for (int i = 0; i < 8; i++) begin
			slow <= i[0];
			run_frame(sa[i], oa[i], 8'(1 + i % 3), i[1:0], i[2]);
		end
		run_frame(15'h0005, 8'h28, 8'h03, 2'h2, 1'b0);
		run_frame(15'h0005 + 15'd43, 8'h28, 8'h03, 2'h2, 1'b0);
		end_sim;
	end

	// hang guard, far beyond the ten short frames
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		end_sim;
	end
endmodule // tb_vdf_fetch
